// [pkg/pmc_defs.svh]
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
// register byte addresses
`define PMC_OSC_CTRL_ADDR 12'h000
`define PMC_IDLE_STOP_ADDR 12'h004
`define PMC_PB_DIV_ADDR 12'h008
`define PMC_PB_STOP_ADDR 12'h00c
`define PMC_STATUS_ADDR 12'h010
`define PMC_WAKE_CNT_ADDR 12'h014
// oscillator control fields
`define PMC_SLEEP_SEL_BIT 4
`define PMC_CPU_DIV_LSB 16
`define PMC_CLK_SRC_LSB 8
// reset values
`define PMC_OSC_CTRL_RST 32'h0000_0000
`define PMC_PB_DIV_RST 32'h0000_0000
`define PMC_WAKE_CNT_RST 16'h0010
`endif

// [pkg/pmc_pkg.sv]
package pmc_pkg;
  typedef enum logic [1:0] {PMC_RUN, PMC_IDLE, PMC_SLEEP, PMC_WAKE} pmc_state_type;
  typedef enum logic [1:0] {PMC_SRC_MAIN, PMC_SRC_LOW_POWER_RC_OSCILLATOR_OSC, PMC_SRC_SEC_OSC, PMC_SRC_EXT}
    pmc_src_type;
endpackage : pmc_pkg

// [rtl/pmc_power_mode_controller.sv]
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// R1: power states entered only by software wait
// R2: per-bus clock divider and stop
// R3: slow cpu, bus seven, or lowpower source
// R4: sleep select clear plus wait enters idle
// R5: sleep select set plus wait enters sleep
// R6: idle halts cpu, clocks keep running
// R7: idle-stop peripherals halt in idle
// R8: sleep halts cpu and most peripherals
// R9: sleep-capable peripherals keep their enables
// R10: fail-safe clock monitor off during sleep
// R11: brownout circuit always active in sleep
// R12: sleep never clears the watchdog counter
// R13: wake-up delay depends on oscillator source
// R14: wake only if priority above cpu priority
// R15: low-priority interrupt in sleep goes idle
// R16: low-priority interrupt in idle stays idle
// R17: reset or watchdog time-out wakes device
`include "pmc_defs.svh"
module pmc_power_mode_controller
  import pmc_pkg::*;
#(
  parameter int NPER = 8,
  parameter int NBUS = 7,
  parameter int PRIW = 3
) (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic [2:0] hsize, // size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // response
  output logic [31:0] hrdata, // read data
  input wire logic wait_exec, // cpu executes wait, pulse
  input wire logic irq_valid, // enabled interrupt pending
  input wire logic [PRIW-1:0] irq_priority, // pending priority
  input wire logic [PRIW-1:0] cpu_priority, // current cpu priority
  input wire logic watchdog_timeout, // watchdog time-out
  input wire logic [NPER-1:0] sleep_capable, // peripherals that run in sleep
  output logic cpu_clk_en, // cpu clock enable
  output logic cpu_wake, // cpu resumes, pulse
  output logic [NBUS-1:0] peripheral_bus_clock_n, // bus clock enables
  output logic [NPER-1:0] periph_run, // peripheral run enables
  output logic fail_safe_clock_monitor_en, // monitor enable
  output logic brownout_reset_circuit_en, // brownout enable
  output logic [1:0] clk_src // selected oscillator source
);
  // ==========================================================
  // register bus: address phase capture
  logic ap_r;
  logic ap_nxt;
  logic aw_r;
  logic aw_nxt;
  logic [11:0] aa_r;
  logic [11:0] aa_nxt;
  logic rd_req;

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rd_req = ap_nxt && !hwrite;

  always_comb begin
    ap_nxt = hsel && hready && htrans[1];
    aw_nxt = hwrite;
    aa_nxt = haddr[11:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_r <= 1'b0;
      aw_r <= 1'b0;
      aa_r <= 12'h000;
    end else begin
      ap_r <= ap_nxt;
      aw_r <= aw_nxt;
      aa_r <= aa_nxt;
    end
  end

  // ==========================================================
  // register bus: write strobes
  // writes land at the end of the data phase, while hwdata stands
  logic wr_osc;
  logic wr_istop;
  logic wr_pdiv;
  logic wr_pstop;
  logic wr_wcnt;

  always_comb begin
    wr_osc = 1'b0;
    wr_istop = 1'b0;
    wr_pdiv = 1'b0;
    wr_pstop = 1'b0;
    wr_wcnt = 1'b0;
    if (ap_r && aw_r) begin
      case (aa_r)
        `PMC_OSC_CTRL_ADDR: wr_osc = 1'b1;
        `PMC_IDLE_STOP_ADDR: wr_istop = 1'b1;
        `PMC_PB_DIV_ADDR: wr_pdiv = 1'b1;
        `PMC_PB_STOP_ADDR: wr_pstop = 1'b1;
        `PMC_WAKE_CNT_ADDR: wr_wcnt = 1'b1;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // control registers
  // divider bits above the last bus are stored but unused
  logic [31:0] osc_r, osc_nxt;
  logic [31:0] pdiv_r, pdiv_nxt;
  logic [NPER-1:0] istop_r, istop_nxt;
  logic [NBUS-1:0] pstop_r, pstop_nxt;
  logic [15:0] wcnt_r, wcnt_nxt;
  logic sleep_sel;

  assign sleep_sel = osc_r[`PMC_SLEEP_SEL_BIT];

  always_comb begin
    osc_nxt = wr_osc ? hwdata : osc_r;
    pdiv_nxt = wr_pdiv ? hwdata : pdiv_r;
    istop_nxt = wr_istop ? hwdata[NPER-1:0] : istop_r;
    pstop_nxt = wr_pstop ? hwdata[NBUS-1:0] : pstop_r;
    wcnt_nxt = wr_wcnt ? hwdata[15:0] : wcnt_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_r <= `PMC_OSC_CTRL_RST;
      pdiv_r <= `PMC_PB_DIV_RST;
      istop_r <= '0;
      pstop_r <= '0;
      wcnt_r <= `PMC_WAKE_CNT_RST;
    end else begin
      osc_r <= osc_nxt;
      pdiv_r <= pdiv_nxt;
      istop_r <= istop_nxt;
      pstop_r <= pstop_nxt;
      wcnt_r <= wcnt_nxt;
    end
  end

  // ==========================================================
  // read data
  // mux sees next values, so a read right behind a write returns it
  pmc_state_type st_r, st_nxt;
  logic [31:0] hrdata_nxt;

  always_comb begin
    hrdata_nxt = 32'h0000_0000;
    if (rd_req) begin
      case (haddr[11:0])
        `PMC_OSC_CTRL_ADDR: hrdata_nxt = osc_nxt;
        `PMC_IDLE_STOP_ADDR: hrdata_nxt = 32'(istop_nxt);
        `PMC_PB_DIV_ADDR: hrdata_nxt = pdiv_nxt;
        `PMC_PB_STOP_ADDR: hrdata_nxt = 32'(pstop_nxt);
        `PMC_STATUS_ADDR: hrdata_nxt = {30'h0, st_r};
        `PMC_WAKE_CNT_ADDR: hrdata_nxt = {16'h0, wcnt_nxt};
        default: hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= hrdata_nxt;
    end
  end

  // ==========================================================
  // power state machine
  logic wake_hi, wake_any;
  logic [15:0] dly_r, dly_nxt;
  // low priority interrupts never wake the cpu, they only lift sleep to idle
  assign wake_hi = irq_valid && (irq_priority > cpu_priority); // R14
  assign wake_any = wake_hi || watchdog_timeout; // R17

  always_comb begin
    st_nxt = st_r;
    dly_nxt = dly_r;
    cpu_wake = 1'b0;
    case (st_r)
      PMC_RUN: begin
        if (wait_exec) begin // R1
          st_nxt = sleep_sel ? PMC_SLEEP : PMC_IDLE; // R4 R5
        end
      end
      PMC_IDLE: begin
        if (wake_any) begin // R16
          st_nxt = PMC_RUN;
          cpu_wake = 1'b1;
        end
      end
      PMC_SLEEP: begin
        if (wake_any) begin
          st_nxt = PMC_WAKE;
          // delay loaded once on the wake event, then counted down
          dly_nxt = (clk_src == PMC_SRC_MAIN) ? wcnt_r : (wcnt_r << 2); // R13
        end else if (irq_valid) begin
          st_nxt = PMC_IDLE; // R15
        end
      end
      PMC_WAKE: begin
        // cpu_wake marks the last wake cycle, run starts at the next edge
        if (dly_r == 16'h0000) begin
          st_nxt = PMC_RUN;
          cpu_wake = 1'b1;
        end else begin
          dly_nxt = dly_r - 16'h0001;
        end
      end
      default: st_nxt = PMC_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= PMC_RUN; // R17
      dly_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      dly_r <= dly_nxt;
    end
  end

  // ==========================================================
  // cpu clock divider
  // reloads on its tick; a divider of zero gives an enable every cycle
  logic [7:0] cpu_cnt_r;
  logic [7:0] cpu_cnt_nxt;
  logic [7:0] cpu_div;
  logic cpu_tick;

  assign cpu_div = osc_r[`PMC_CPU_DIV_LSB +: 8];
  assign cpu_clk_en = (st_r == PMC_RUN) && cpu_tick; // R3 R6 R8

  always_comb begin
    cpu_tick = (cpu_cnt_r == 8'h00);
    if (cpu_tick) begin
      cpu_cnt_nxt = cpu_div; // R3
    end else begin
      cpu_cnt_nxt = cpu_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_cnt_r <= 8'h00;
    end else begin
      cpu_cnt_r <= cpu_cnt_nxt;
    end
  end

  // ==========================================================
  // peripheral bus dividers, one counter per bus
  genvar g;
  generate
    for (g = 0; g < NBUS; g++) begin : g_bus
      logic [3:0] cnt_r;
      logic [3:0] cnt_nxt;
      logic [3:0] div;
      logic tick;
      assign div = pdiv_r[g*4 +: 4];
      always_comb begin
        tick = (cnt_r == 4'h0);
        if (tick) begin
          cnt_nxt = div; // R2
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_r <= 4'h0;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end
      // stop or sleep holds the enable low, the count keeps going
      assign peripheral_bus_clock_n[g] = tick && !pstop_r[g] && (st_r != PMC_SLEEP); // R2 R8
    end
  endgenerate

  // ==========================================================
  // peripheral run and monitor enables

  always_comb begin
    case (st_r)
      PMC_IDLE: periph_run = ~istop_r; // R7
      PMC_SLEEP, PMC_WAKE: periph_run = sleep_capable; // R8 R9
      default: periph_run = {NPER{1'b1}};
    endcase
  end

  assign clk_src = osc_r[`PMC_CLK_SRC_LSB +: 2]; // R3
  assign fail_safe_clock_monitor_en = (st_r != PMC_SLEEP); // R10
  assign brownout_reset_circuit_en = 1'b1; // R11
  // watchdog counter is untouched on sleep entry: no clear output exists R12
endmodule : pmc_power_mode_controller

// [sim/pmc_props.sv]
`timescale 1ns/1ps
// ==========
// power mode checks
module pmc_props #(
  parameter int NPER = 8,
  parameter int NBUS = 7
) (
  input wire logic hclk, // clk
  input wire logic hresetn, // rst
  input wire logic hreadyout, // rdy
  input wire logic hresp, // resp
  input wire logic wait_exec, // wait
  input wire logic irq_valid, // irq
  input wire logic watchdog_timeout, // wdt
  input wire logic [NPER-1:0] sleep_capable, // cap
  input wire logic cpu_clk_en, // cpu
  input wire logic cpu_wake, // wake
  input wire logic [NBUS-1:0] peripheral_bus_clock_n, // bus
  input wire logic [NPER-1:0] periph_run, // run
  input wire logic fail_safe_clock_monitor_en, // fail_safe_clock_monitor
  input wire logic brownout_reset_circuit_en // bor
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_bor; brownout_reset_circuit_en; endproperty
  a_bor: assert property (p_bor) else $error("brownout off");
  property p_resp; hreadyout && !hresp; endproperty
  a_resp: assert property (p_resp) else $error("bus resp");
  property p_ent; $fell(fail_safe_clock_monitor_en) |-> $past(wait_exec); endproperty
  a_ent: assert property (p_ent) else $error("sleep no wait");
  property p_slp;
    !fail_safe_clock_monitor_en |-> periph_run == sleep_capable && !cpu_clk_en
      && peripheral_bus_clock_n == '0;
  endproperty
  a_slp: assert property (p_slp) else $error("sleep outs");
  property p_exit;
    !fail_safe_clock_monitor_en && (watchdog_timeout || irq_valid)
      |=> fail_safe_clock_monitor_en;
  endproperty
  a_exit: assert property (p_exit) else $error("no exit");
  property p_wait; cpu_clk_en && wait_exec |=> !cpu_clk_en; endproperty
  a_wait: assert property (p_wait) else $error("wait ignored");
  property p_wake; cpu_wake |-> !cpu_clk_en ##1 periph_run == '1; endproperty
  a_wake: assert property (p_wake) else $error("wake run");
  property p_pulse; cpu_wake |=> !cpu_wake; endproperty
  a_pulse: assert property (p_pulse) else $error("wake pulse");
  c_sleep: cover property ($fell(fail_safe_clock_monitor_en));
  c_low: cover property (!fail_safe_clock_monitor_en && irq_valid);
  c_wake: cover property (cpu_wake);
endmodule : pmc_props
bind pmc_power_mode_controller pmc_props #(.NPER(NPER), .NBUS(NBUS)) i_pmc_props (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .wait_exec(wait_exec), .irq_valid(irq_valid), .watchdog_timeout(watchdog_timeout),
  .sleep_capable(sleep_capable), .cpu_clk_en(cpu_clk_en), .cpu_wake(cpu_wake),
  .peripheral_bus_clock_n(peripheral_bus_clock_n), .periph_run(periph_run),
  .fail_safe_clock_monitor_en(fail_safe_clock_monitor_en),
  .brownout_reset_circuit_en(brownout_reset_circuit_en));

// [sim/pmc_core_model.sv]
`timescale 1ns/1ps
// ==========
// core side: wait and interrupt requests
module pmc_core_model (
  input wire logic hclk, // clk
  input wire logic do_wait, // wait req
  input wire logic do_irq, // irq req
  input wire logic [2:0] pri, // irq priority
  output logic wait_exec, // to block
  output logic irq_valid, // to block
  output logic [2:0] irq_priority // to block
);
  always @(posedge hclk) begin
    wait_exec <= do_wait;
    irq_valid <= do_irq;
    irq_priority <= pri;
  end
endmodule : pmc_core_model

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import pmc_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hresp, hreadyout;
  logic [1:0] htrans = 0, cs;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r, v;
  logic do_w = 0, do_i = 0, wdt = 0, we, iv, cce, cw, fe, be;
  logic [2:0] ip = 0, cp = 0, ipr;
  logic [7:0] sc = 0, pr;
  logic [6:0] pb;
  int err_total = 0, checked = 0, cyc = 0, n;
  always #50 hclk = ~hclk;
  pmc_power_mode_controller i_pmc_power_mode_controller (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .wait_exec(we), .irq_valid(iv), .irq_priority(ipr),
    .cpu_priority(cp), .watchdog_timeout(wdt), .sleep_capable(sc), .cpu_clk_en(cce),
    .cpu_wake(cw), .peripheral_bus_clock_n(pb), .periph_run(pr),
    .fail_safe_clock_monitor_en(fe), .brownout_reset_circuit_en(be), .clk_src(cs));
  pmc_core_model i_pmc_core_model (.hclk(hclk), .do_wait(do_w), .do_irq(do_i), .pri(ip),
    .wait_exec(we), .irq_valid(iv), .irq_priority(ipr));
  task close_out;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task go(input logic i, input logic [2:0] p);
    @(posedge hclk);
    {do_w, do_i, ip} <= {~i, i, p};
    @(posedge hclk);
    {do_w, do_i} <= 2'h0;
    repeat (2) @(posedge hclk);
    bus(0, 'h10, 0);
  endtask : go
  function automatic int wexp(int c, int s);
    return (s != 0) ? c * 4 + 1 : c + 1;
  endfunction : wexp
  always @(posedge hclk) if (++cyc > 20000) begin
    err_total++;
    close_out;
  end
  initial begin
    v = $urandom(32'h1da3);
    repeat (12) @(posedge hclk);
    hresetn <= 1;
    bus(0, 'h10, 0); chk("status", 0, r);
    bus(0, 'h14, 0); chk("wake_cnt", 32'h10, r);
    bus(0, 'h20, 0); chk("unmapped", 0, r);
    v = $urandom; bus(1, 'h0c, v & 'h7f); #1 chk("bus_stop", {25'h0, ~v[6:0]}, pb);
    bus(1, 'h0c, 0); v = $urandom; bus(1, 'h04, v & 'hff); cp <= 3;
    go(0, 0); chk("idle", 1, r);
    chk("idle_run", {24'h0, ~v[7:0]}, pr);
    chk("idle_bus", 'h7f, pb);
    go(1, 3); chk("idle_low", 1, r);
    go(1, 4); chk("idle_wake", 0, r);
    sc <= 8'($urandom); bus(1, 0, 'h10);
    go(0, 0); chk("sleep", 2, r);
    chk("sleep_run", sc, pr);
    chk("fail_safe_clock_monitor", 0, fe);
    chk("bor", 1, be);
    go(1, 2); chk("sleep_low", 1, r);
    go(1, 7); chk("low_wake", 0, r);
    for (int s = 0; s < 2; s++) begin
      bus(1, 'h14, 3); bus(1, 0, 'h10 | (s << 8)); go(0, 0);
      chk("clk_src", s, cs);
      @(posedge hclk); wdt <= 1;
      @(posedge hclk); wdt <= 0;
      n = 1; // counts the edge into wake as well
      while (cw !== 1'b1) begin
        @(posedge hclk);
        #1 n++;
      end
      chk("wake_delay", wexp(3, s), n);
    end
    go(0, 0); chk("sleep_again", 2, r);
    @(posedge hclk); hresetn <= 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    bus(0, 'h10, 0); chk("reset_wake", 0, r);
    chk("reset_fail_safe_clock_monitor", 1, fe);
    close_out;
  end
endmodule : testbench
